/* verilog/pgh_alt_mux.sv */
// port g / port h alternate function override mux with registered pin controls
`include "pgh_consts.svh"
`timescale 1ns/1ps
module pgh_alt_mux (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // port registers
  input  wire pgh_pkg::pgh_gvec_type port_g_direction,
  input  wire pgh_pkg::pgh_gvec_type port_g_output,
  input  wire pgh_pkg::pgh_hvec_type port_h_direction,
  input  wire pgh_pkg::pgh_hvec_type port_h_output,
  input  wire logic              global_pullup_disable,
  // pin levels
  input  wire pgh_pkg::pgh_gvec_type port_g_pin_in,
  input  wire pgh_pkg::pgh_hvec_type port_h_pin_in,
  input  wire pgh_pkg::pgh_hvec_type port_j_pin_in,
  // timers
  input  wire logic              timer0_compare_b_enable,
  input  wire logic              timer0_compare_b_out,
  input  wire logic              timer2_async_clock_select,
  input  wire logic              external_clock_input_select,
  input  wire logic              timer2_compare_b_enable,
  input  wire logic              timer2_compare_b_out,
  input  wire logic              timer4_compare_a_enable,
  input  wire logic              timer4_compare_a_out,
  input  wire logic              timer4_compare_b_enable,
  input  wire logic              timer4_compare_b_out,
  input  wire logic              timer4_compare_c_enable,
  input  wire logic              timer4_compare_c_out,
  // external memory interface
  input  wire logic              ext_memory_interface_enable,
  input  wire logic              ext_mem_addr_latch_enable,
  input  wire logic              ext_mem_read_strobe,
  input  wire logic              ext_mem_write_strobe,
  // serial port 2
  input  wire logic              serial2_sync_mode,
  input  wire logic              serial2_clock_out,
  input  wire logic              serial2_transmitter_enable,
  input  wire logic              serial2_transmit_line,
  input  wire logic              serial2_receiver_enable,
  // resolved pin controls
  output pgh_pkg::pgh_gvec_type  port_g_pullup,
  output pgh_pkg::pgh_gvec_type  port_g_dir,
  output pgh_pkg::pgh_gvec_type  port_g_out,
  output pgh_pkg::pgh_gvec_type  port_g_input_en,
  output pgh_pkg::pgh_gvec_type  port_g_read,
  output pgh_pkg::pgh_hvec_type  port_h_pullup,
  output pgh_pkg::pgh_hvec_type  port_h_dir,
  output pgh_pkg::pgh_hvec_type  port_h_out,
  output pgh_pkg::pgh_hvec_type  port_h_input_en,
  output pgh_pkg::pgh_hvec_type  port_h_read,
  // peripheral side
  output logic                   timer_osc_input_attached,
  output logic                   timer_osc_output_attached,
  output logic                   timer_osc_input_pin,
  output logic                   timer4_clock_input,
  output logic                   serial2_external_clock,
  output logic                   serial2_receive_line,
  output pgh_pkg::pgh_pcsrc_type pin_change_source,
  output logic                   serial3_external_clock,
  output logic                   serial3_receive_line
);

  // ----------------------------------------------------------------
  // override vectors, port g in bits 5..0, port h in bits 13..6
  // ----------------------------------------------------------------
  pgh_pkg::pgh_pins_type pu_en_v;
  pgh_pkg::pgh_pins_type pu_val_v;
  pgh_pkg::pgh_pins_type dir_en_v;
  pgh_pkg::pgh_pins_type dir_val_v;
  pgh_pkg::pgh_pins_type val_en_v;
  pgh_pkg::pgh_pins_type val_val_v;
  pgh_pkg::pgh_pins_type ieoe_v;
  pgh_pkg::pgh_pins_type ieov_v;
  pgh_pkg::pgh_pins_type all_dir;
  pgh_pkg::pgh_pins_type all_out;
  pgh_pkg::pgh_pins_type res_pull;
  pgh_pkg::pgh_pins_type res_dir;
  pgh_pkg::pgh_pins_type res_out;
  pgh_pkg::pgh_pins_type res_ie;
  pgh_pkg::pgh_hvec_type h_pe;
  pgh_pkg::pgh_hvec_type h_pv;
  pgh_pkg::pgh_hvec_type h_de;
  pgh_pkg::pgh_hvec_type h_dv;
  pgh_pkg::pgh_hvec_type h_ue;
  pgh_pkg::pgh_hvec_type h_uv;
  pgh_pkg::pgh_gvec_type g_pe;
  pgh_pkg::pgh_gvec_type g_pv;
  pgh_pkg::pgh_gvec_type g_de;
  pgh_pkg::pgh_gvec_type g_dv;
  pgh_pkg::pgh_gvec_type g_ue;
  pgh_pkg::pgh_gvec_type g_ie;
  pgh_pkg::pgh_gvec_type g_iv;
  logic osc_ext;
  logic xclk_drive;

  assign all_dir = {port_h_direction, port_g_direction};
  assign all_out = {port_h_output, port_g_output};

  // override enables and values per pin; zero enable leaves port registers in charge, input enable at its default
  always_comb begin
    osc_ext    = timer2_async_clock_select & external_clock_input_select;
    // clock pin only driven in synchronous mode with direction bit set
    xclk_drive = serial2_sync_mode & port_h_direction[`PGH_H_XCLK];
    g_pe = '0;
    g_pv = '0;
    g_de = '0;
    g_dv = '0;
    g_ue = '0;
    g_ie = '0;
    g_iv = '0;
    h_pe = '0;
    h_pv = '0;
    h_de = '0;
    h_dv = '0;
    h_ue = '0;
    h_uv = '0;
    // value override only; pin reaches the wire only if direction is output
    g_pe[`PGH_G_T0CMPB] = timer0_compare_b_enable;
    g_pv[`PGH_G_T0CMPB] = timer0_compare_b_out;
    // oscillator input pin: no pull-up, input, input gate follows ext clock
    g_ue[`PGH_G_OSC_IN] = timer2_async_clock_select;
    g_de[`PGH_G_OSC_IN] = timer2_async_clock_select;
    g_ie[`PGH_G_OSC_IN] = timer2_async_clock_select;
    g_iv[`PGH_G_OSC_IN] = external_clock_input_select;
    // oscillator output pin overrides need both select bits
    g_ue[`PGH_G_OSC_OUT] = osc_ext;
    g_de[`PGH_G_OSC_OUT] = osc_ext;
    g_ie[`PGH_G_OSC_OUT] = osc_ext;
    // external memory strobes take all three low pins as outputs
    g_ue[2:0] = {3{ext_memory_interface_enable}};
    g_de[2:0] = {3{ext_memory_interface_enable}};
    g_dv[2:0] = 3'h7;
    g_pe[2:0] = {3{ext_memory_interface_enable}};
    g_pv[`PGH_G_LATCH] = ext_mem_addr_latch_enable;
    g_pv[`PGH_G_READ]  = ext_mem_read_strobe;
    g_pv[`PGH_G_WRITE] = ext_mem_write_strobe;
    // timer4 clock pin has no overrides at all
    // compare outputs replace the port value when enabled
    h_pe[`PGH_H_T2CMPB] = timer2_compare_b_enable;
    h_pv[`PGH_H_T2CMPB] = timer2_compare_b_out;
    h_pe[`PGH_H_T4CMPC] = timer4_compare_c_enable;
    h_pv[`PGH_H_T4CMPC] = timer4_compare_c_out;
    h_pe[`PGH_H_T4CMPB] = timer4_compare_b_enable;
    h_pv[`PGH_H_T4CMPB] = timer4_compare_b_out;
    h_pe[`PGH_H_T4CMPA] = timer4_compare_a_enable;
    h_pv[`PGH_H_T4CMPA] = timer4_compare_a_out;
    // serial clock driven out as output when enabled
    h_de[`PGH_H_XCLK] = xclk_drive;
    h_dv[`PGH_H_XCLK] = 1'b1;
    h_pe[`PGH_H_XCLK] = xclk_drive;
    h_pv[`PGH_H_XCLK] = serial2_clock_out;
    // transmitter owns the tx pin
    h_ue[`PGH_H_TX] = serial2_transmitter_enable;
    h_de[`PGH_H_TX] = serial2_transmitter_enable;
    h_dv[`PGH_H_TX] = 1'b1;
    h_pe[`PGH_H_TX] = serial2_transmitter_enable;
    h_pv[`PGH_H_TX] = serial2_transmit_line;
    // receiver forces input; pull-up stays under software control
    h_de[`PGH_H_RX] = serial2_receiver_enable;
    h_dv[`PGH_H_RX] = 1'b0;
    h_ue[`PGH_H_RX] = serial2_receiver_enable;
    h_uv[`PGH_H_RX] = port_h_output[`PGH_H_RX] & ~global_pullup_disable;
    pu_en_v   = {h_ue, g_ue};
    pu_val_v  = {h_uv, 6'h00};
    dir_en_v  = {h_de, g_de};
    dir_val_v = {h_dv, g_dv};
    val_en_v  = {h_pe, g_pe};
    val_val_v = {h_pv, g_pv};
    ieoe_v = {8'h00, g_ie};
    ieov_v = {8'h00, g_iv};
  end

  // ----------------------------------------------------------------
  // per pin resolution
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 14; i++) begin : g_pin
    // low enables fall through to port registers; input enable falls to PGH_IE_DEFAULT
    pgh_pin_override u_pin (
      .port_direction               (all_dir[i]),
      .port_output                  (all_out[i]),
      .global_pullup_disable        (global_pullup_disable),
      .pullup_override_enable       (pu_en_v[i]),
      .pullup_override_value        (pu_val_v[i]),
      .direction_override_enable    (dir_en_v[i]),
      .direction_override_value     (dir_val_v[i]),
      .pin_value_override_enable    (val_en_v[i]),
      .pin_value_override_value     (val_val_v[i]),
      .input_enable_override_enable (ieoe_v[i]),
      .input_enable_override_value  (ieov_v[i]),
      .pin_pullup                   (res_pull[i]),
      .pin_direction                (res_dir[i]),
      .pin_output                   (res_out[i]),
      .pin_input_enable             (res_ie[i])
    );
  end

  // ----------------------------------------------------------------
  // next values and output registers
  // ----------------------------------------------------------------
  pgh_pkg::pgh_pins_type next_pull;
  pgh_pkg::pgh_pins_type next_dir;
  pgh_pkg::pgh_pins_type next_out;
  pgh_pkg::pgh_pins_type next_ie;
  pgh_pkg::pgh_pins_type next_read;
  pgh_pkg::pgh_pcsrc_type next_pcsrc;
  logic next_osc_in_att;
  logic next_osc_out_att;
  logic next_osc_pin;
  logic next_t4clk;
  logic next_s2clk;
  logic next_s2rx;
  logic next_s3clk;
  logic next_s3rx;

  // one register stage keeps every output glitch free at the cost of a cycle
  always_comb begin
    next_pull  = res_pull;
    next_dir   = res_dir;
    next_out   = res_out;
    next_ie    = res_ie;
    // a disabled input buffer reads as zero
    next_read  = {port_h_pin_in, port_g_pin_in} & res_ie;
    next_osc_in_att  = timer2_async_clock_select;
    next_osc_out_att = timer2_async_clock_select;
    // external clock arrives on the oscillator input pin
    next_osc_pin = osc_ext & port_g_pin_in[`PGH_G_OSC_IN];
    next_t4clk   = port_h_pin_in[`PGH_H_T4CLK];
    // clock taken in only in synchronous mode with direction cleared
    next_s2clk   = serial2_sync_mode & ~port_h_direction[`PGH_H_XCLK]
                 & port_h_pin_in[`PGH_H_XCLK];
    next_s2rx    = port_h_pin_in[`PGH_H_RX];
    next_pcsrc   = port_j_pin_in[`PGH_J_PC_TOP:0];
    next_s3clk   = port_j_pin_in[`PGH_J_XCLK];
    next_s3rx    = port_j_pin_in[`PGH_J_RX];
  end

  // plain registering with synchronous reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      {port_h_pullup, port_g_pullup}     <= '0;
      {port_h_dir, port_g_dir}           <= '0;
      {port_h_out, port_g_out}           <= '0;
      {port_h_input_en, port_g_input_en} <= '0;
      {port_h_read, port_g_read}         <= '0;
      timer_osc_input_attached           <= `PGH_RST_LEVEL;
      timer_osc_output_attached          <= `PGH_RST_LEVEL;
      timer_osc_input_pin                <= `PGH_RST_LEVEL;
      timer4_clock_input                 <= `PGH_RST_LEVEL;
      serial2_external_clock             <= `PGH_RST_LEVEL;
      serial2_receive_line               <= `PGH_RST_LEVEL;
      pin_change_source                  <= '0;
      serial3_external_clock             <= `PGH_RST_LEVEL;
      serial3_receive_line               <= `PGH_RST_LEVEL;
    end else begin
      {port_h_pullup, port_g_pullup}     <= next_pull;
      {port_h_dir, port_g_dir}           <= next_dir;
      {port_h_out, port_g_out}           <= next_out;
      {port_h_input_en, port_g_input_en} <= next_ie;
      {port_h_read, port_g_read}         <= next_read;
      timer_osc_input_attached           <= next_osc_in_att;
      timer_osc_output_attached          <= next_osc_out_att;
      timer_osc_input_pin                <= next_osc_pin;
      timer4_clock_input                 <= next_t4clk;
      serial2_external_clock             <= next_s2clk;
      serial2_receive_line               <= next_s2rx;
      pin_change_source                  <= next_pcsrc;
      serial3_external_clock             <= next_s3clk;
      serial3_receive_line               <= next_s3rx;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_t0_cmp_pin: assert property (
    timer0_compare_b_enable |=> port_g_out[5] == $past(timer0_compare_b_out))
    else $error("g5 does not carry timer0 compare b");
  chk_osc_in_force: assert property (
    timer2_async_clock_select |=> !port_g_pullup[4] && !port_g_dir[4]
      && port_g_input_en[4] == $past(external_clock_input_select) && timer_osc_input_attached)
    else $error("g4 oscillator overrides wrong");
  chk_osc_out_force: assert property (
    (timer2_async_clock_select && external_clock_input_select)
      |=> !port_g_pullup[3] && !port_g_dir[3] && !port_g_input_en[3])
    else $error("g3 oscillator overrides wrong");
  chk_osc_out_partial: assert property (
    (timer2_async_clock_select && !external_clock_input_select)
      |=> timer_osc_output_attached && port_g_input_en[3] && port_g_dir[3] == $past(port_g_direction[3]))
    else $error("g3 overridden without external clock");
  chk_ext_mem_pins: assert property (
    ext_memory_interface_enable |=> port_g_dir[2:0] == 3'h7 && port_g_pullup[2:0] == 3'h0
      && port_g_out[2] == $past(ext_mem_addr_latch_enable) && port_g_out[1] == $past(ext_mem_read_strobe)
      && port_g_out[0] == $past(ext_mem_write_strobe))
    else $error("external memory strobes not on g2..g0");
  chk_t4_clock_feed: assert property (
    ##1 timer4_clock_input == $past(port_h_pin_in[7]) && port_h_dir[7] == $past(port_h_direction[7]))
    else $error("timer4 clock feed wrong");
  chk_h_cmp_outputs: assert property (
    (timer2_compare_b_enable && timer4_compare_a_enable) |=> port_h_out[6] == $past(timer2_compare_b_out)
      && port_h_out[3] == $past(timer4_compare_a_out) && port_h_dir[6] == $past(port_h_direction[6]))
    else $error("compare output not on port h");
  chk_xclk_dir: assert property (
    (serial2_sync_mode && port_h_direction[2]) |=> port_h_dir[2] && port_h_out[2] == $past(serial2_clock_out)
      && !serial2_external_clock)
    else $error("serial2 clock pin wrong");
  chk_tx_force: assert property (
    serial2_transmitter_enable |=> port_h_dir[1] && !port_h_pullup[1]
      && port_h_out[1] == $past(serial2_transmit_line))
    else $error("tx pin not forced");
  chk_rx_force: assert property (
    serial2_receiver_enable |=> !port_h_dir[0]
      && port_h_pullup[0] == ($past(port_h_output[0]) && !$past(global_pullup_disable))
      && serial2_receive_line == $past(port_h_pin_in[0]))
    else $error("rx pin not forced to input");
  chk_pc_sources: assert property (
    ##1 pin_change_source == $past(port_j_pin_in[6:0]))
    else $error("pin change sources wrong");
  chk_plain_follow: assert property (
    !ext_memory_interface_enable |=> port_g_dir[2:0] == $past(port_g_direction[2:0])
      && port_g_out[2:0] == $past(port_g_output[2:0]))
    else $error("port g low pins do not follow port registers");

  cov_async_ext: cover property (timer2_async_clock_select && external_clock_input_select ##1 1'b1);
  cov_ext_mem: cover property (ext_memory_interface_enable ##1 !ext_memory_interface_enable);
  cov_serial2_both: cover property (serial2_transmitter_enable && serial2_receiver_enable);
  cov_sync_clock_in: cover property (serial2_sync_mode && !port_h_direction[2] && port_h_pin_in[2]);

endmodule : pgh_alt_mux

/* verilog/pgh_consts.svh */
// constants for the port g / port h alternate function override block
`ifndef PGH_CONSTS_SVH
`define PGH_CONSTS_SVH

// ----------------------------------------------------------------
// pin positions on port g
// ----------------------------------------------------------------
`define PGH_G_T0CMPB   5
`define PGH_G_OSC_IN   4
`define PGH_G_OSC_OUT  3
`define PGH_G_LATCH    2
`define PGH_G_READ     1
`define PGH_G_WRITE    0

// ----------------------------------------------------------------
// pin positions on port h
// ----------------------------------------------------------------
`define PGH_H_T4CLK    7
`define PGH_H_T2CMPB   6
`define PGH_H_T4CMPC   5
`define PGH_H_T4CMPB   4
`define PGH_H_T4CMPA   3
`define PGH_H_XCLK     2
`define PGH_H_TX       1
`define PGH_H_RX       0

// ----------------------------------------------------------------
// port j: pin change sources and serial port 3 pins
// ----------------------------------------------------------------
`define PGH_J_PC_TOP   6
`define PGH_J_XCLK     2
`define PGH_J_RX       0

// ----------------------------------------------------------------
// reset values and defaults
// ----------------------------------------------------------------
`define PGH_RST_LEVEL  1'b0
`define PGH_IE_DEFAULT 1'b1

`endif

/* verilog/pgh_pkg.sv */
// types shared by the port g / port h alternate function override block
package pgh_pkg;
  typedef logic [5:0]  pgh_gvec_type;
  typedef logic [7:0]  pgh_hvec_type;
  typedef logic [13:0] pgh_pins_type;
  typedef logic [6:0]  pgh_pcsrc_type;
endpackage : pgh_pkg

/* verilog/pgh_pin_override.sv */
// one pin's override resolver: alternate function wins over the port registers
`include "pgh_consts.svh"
`timescale 1ns/1ps
module pgh_pin_override (
  input  wire logic port_direction,
  input  wire logic port_output,
  input  wire logic global_pullup_disable,
  input  wire logic pullup_override_enable,
  input  wire logic pullup_override_value,
  input  wire logic direction_override_enable,
  input  wire logic direction_override_value,
  input  wire logic pin_value_override_enable,
  input  wire logic pin_value_override_value,
  input  wire logic input_enable_override_enable,
  input  wire logic input_enable_override_value,
  output logic      pin_pullup,
  output logic      pin_direction,
  output logic      pin_output,
  output logic      pin_input_enable
);
  // ----------------------------------------------------------------
  // resolution
  // ----------------------------------------------------------------
  // plain port pull-up: input pin, output bit one, pull-ups allowed
  assign pin_pullup       = pullup_override_enable ? pullup_override_value
                          : (~port_direction & port_output & ~global_pullup_disable);
  assign pin_direction    = direction_override_enable ? direction_override_value : port_direction;
  assign pin_output       = pin_value_override_enable ? pin_value_override_value : port_output;
  assign pin_input_enable = input_enable_override_enable ? input_enable_override_value : `PGH_IE_DEFAULT;
endmodule : pgh_pin_override

/* tb/pgh_periph_model.sv */
// peripheral side model: timers, serial port 2 and external memory strobes
`timescale 1ns/1ps
module pgh_periph_model (
  input  wire logic mclk,
  input  wire logic sys_rst,
  output logic      ext_mem_addr_latch_enable,
  output logic      ext_mem_read_strobe,
  output logic      ext_mem_write_strobe,
  output logic      timer0_compare_b_out,
  output logic      timer2_compare_b_out,
  output logic      timer4_compare_a_out,
  output logic      timer4_compare_b_out,
  output logic      timer4_compare_c_out,
  output logic      serial2_clock_out,
  output logic      serial2_transmit_line
);
  logic [3:0] cnt;
  // -------------------------------------------------------
  // free running pattern, moves 1 ns after each rising edge
  // -------------------------------------------------------
  // every line changes often so a stuck mux path shows up
  always @(posedge mclk) begin
    cnt <= #1 sys_rst ? 4'h5 : cnt + 4'h3;
  end
  assign {ext_mem_addr_latch_enable, ext_mem_read_strobe, ext_mem_write_strobe} = cnt[2:0] ^ {2'h0, cnt[3]};
  assign {timer0_compare_b_out, timer2_compare_b_out, timer4_compare_c_out} = ~cnt[3:1];
  assign {timer4_compare_b_out, timer4_compare_a_out} = {cnt[0], cnt[2] ^ cnt[0]};
  assign {serial2_clock_out, serial2_transmit_line} = {cnt[1], cnt[3] ^ cnt[1]};
endmodule : pgh_periph_model

/* tb/tb_top.sv */
// self-checking bench for the port g / port h override mux
`timescale 1ns/1ps
module tb_top;
  logic mclk, sys_rst, global_pullup_disable;
  pgh_pkg::pgh_gvec_type port_g_direction, port_g_output, port_g_pin_in;
  pgh_pkg::pgh_gvec_type port_g_pullup, port_g_dir, port_g_out, port_g_input_en, port_g_read;
  pgh_pkg::pgh_hvec_type port_h_direction, port_h_output, port_h_pin_in, port_j_pin_in;
  pgh_pkg::pgh_hvec_type port_h_pullup, port_h_dir, port_h_out, port_h_input_en, port_h_read;
  pgh_pkg::pgh_pcsrc_type pin_change_source;
  logic timer0_compare_b_enable, timer0_compare_b_out, timer2_async_clock_select, external_clock_input_select;
  logic timer2_compare_b_enable, timer2_compare_b_out, timer4_compare_a_enable, timer4_compare_a_out;
  logic timer4_compare_b_enable, timer4_compare_b_out, timer4_compare_c_enable, timer4_compare_c_out;
  logic ext_memory_interface_enable, ext_mem_addr_latch_enable, ext_mem_read_strobe, ext_mem_write_strobe;
  logic serial2_sync_mode, serial2_clock_out, serial2_transmitter_enable, serial2_transmit_line;
  logic serial2_receiver_enable, timer_osc_input_attached, timer_osc_output_attached, timer_osc_input_pin;
  logic timer4_clock_input, serial2_external_clock, serial2_receive_line, serial3_external_clock;
  logic serial3_receive_line;
  int   bad_count, n_checks, cycles;
  logic [4:0] c;
  logic [2:0] s;
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
  pgh_alt_mux      i_pgh_alt_mux (
    .mclk, .sys_rst, .port_g_direction, .port_g_output, .port_h_direction, .port_h_output,
    .global_pullup_disable, .port_g_pin_in, .port_h_pin_in, .port_j_pin_in,
    .timer0_compare_b_enable, .timer0_compare_b_out, .timer2_async_clock_select, .external_clock_input_select,
    .timer2_compare_b_enable, .timer2_compare_b_out, .timer4_compare_a_enable, .timer4_compare_a_out,
    .timer4_compare_b_enable, .timer4_compare_b_out, .timer4_compare_c_enable, .timer4_compare_c_out,
    .ext_memory_interface_enable, .ext_mem_addr_latch_enable, .ext_mem_read_strobe, .ext_mem_write_strobe,
    .serial2_sync_mode, .serial2_clock_out, .serial2_transmitter_enable, .serial2_transmit_line,
    .serial2_receiver_enable, .port_g_pullup, .port_g_dir, .port_g_out, .port_g_input_en, .port_g_read,
    .port_h_pullup, .port_h_dir, .port_h_out, .port_h_input_en, .port_h_read,
    .timer_osc_input_attached, .timer_osc_output_attached, .timer_osc_input_pin, .timer4_clock_input,
    .serial2_external_clock, .serial2_receive_line, .pin_change_source, .serial3_external_clock,
    .serial3_receive_line);
  pgh_periph_model i_pgh_periph_model (
    .mclk, .sys_rst, .ext_mem_addr_latch_enable, .ext_mem_read_strobe, .ext_mem_write_strobe,
    .timer0_compare_b_out, .timer2_compare_b_out, .timer4_compare_a_out, .timer4_compare_b_out,
    .timer4_compare_c_out, .serial2_clock_out, .serial2_transmit_line);
  // -------------------------------------------------------
  // clock, timeout and closing
  // -------------------------------------------------------
  always #5 mclk = ~mclk;
  // run needs well under 100 cycles, so 2000 only trips on a hang
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // inputs always move 2 ns after the edge, after the model's 1 ns
  task automatic tick();
    @(posedge mclk);
    #2;
  endtask : tick
  task automatic t_extmem();
    {port_g_direction, port_g_output, ext_memory_interface_enable} = {6'h00, 6'h3f, 1'b1};
    for (int i = 0; i < 4; i++) begin
      s = {ext_mem_addr_latch_enable, ext_mem_read_strobe, ext_mem_write_strobe};
      tick();
      `CHK(port_g_dir[2:0], 3'h7)
      `CHK(port_g_pullup[2:0], 3'h0)
      `CHK(port_g_out[2:0], s)
    end
    {ext_memory_interface_enable, port_g_direction} = {1'b0, 6'h05};
    tick();
    `CHK({port_g_dir[2:0], port_g_out[2:0], port_g_pullup[2:0]}, 9'h17a)
    $display("test extmem done");
  endtask : t_extmem
  task automatic t_osc();
    {timer2_async_clock_select, port_g_direction, port_g_output, port_g_pin_in} = {1'b1, 6'h18, 6'h18, 6'h10};
    for (int x = 0; x < 2; x++) begin
      external_clock_input_select = x[0];
      tick();
      `CHK({port_g_pullup[4:3], port_g_dir[4:3]}, {3'h0, ~x[0]})
      `CHK({port_g_input_en[4:3], port_g_read[4]}, {x[0], ~x[0], x[0]})
      `CHK({timer_osc_input_attached, timer_osc_output_attached, timer_osc_input_pin}, {2'h3, x[0]})
    end
    timer2_async_clock_select = 1'b0;
    tick();
    `CHK({port_g_dir[4:3], port_g_input_en[4:3], timer_osc_input_attached}, 5'h1e)
    $display("test osc done");
  endtask : t_osc
  task automatic t_cmp();
    {port_g_direction, port_h_direction, port_g_output, port_h_output} = {6'h20, 8'h78, 6'h00, 8'h00};
    for (int i = 0; i < 4; i++) begin
      {timer0_compare_b_enable, timer2_compare_b_enable, timer4_compare_c_enable, timer4_compare_b_enable,
       timer4_compare_a_enable} = (i == 3) ? 5'h0a : 5'h1f;
      c = {timer0_compare_b_out, timer2_compare_b_out, timer4_compare_c_out, timer4_compare_b_out,
           timer4_compare_a_out} & ((i == 3) ? 5'h0a : 5'h1f);
      tick();
      `CHK({port_g_out[5], port_h_out[6:3]}, c)
      `CHK({port_g_dir[5], port_h_dir[6:3]}, 5'h1f)
    end
    $display("test compare done");
  endtask : t_cmp
  task automatic t_serial();
    {port_h_direction, port_h_output, port_h_pin_in, global_pullup_disable} = {8'h05, 8'h03, 8'h01, 1'b0};
    {serial2_transmitter_enable, serial2_receiver_enable, serial2_sync_mode} = 3'h7;
    s[1:0] = {serial2_clock_out, serial2_transmit_line};
    tick();
    `CHK({port_h_dir[2:0], port_h_out[2:1]}, {3'h6, s[1:0]})
    `CHK({port_h_pullup[1:0], serial2_receive_line}, 3'h3)
    {global_pullup_disable, port_h_direction, port_h_pin_in} = {1'b1, 8'h00, 8'h04};
    tick();
    `CHK({port_h_pullup[0], serial2_external_clock, port_h_dir[2:0]}, 5'h0a)
    {serial2_transmitter_enable, serial2_receiver_enable, serial2_sync_mode} = 3'h0;
    tick();
    `CHK({serial2_external_clock, port_h_dir[2:0]}, 4'h0)
    $display("test serial done");
  endtask : t_serial
  task automatic t_inputs();
    for (int i = 0; i < 2; i++) begin
      {port_h_pin_in, port_j_pin_in} = i ? 16'h8055 : 16'h7faa;
      tick();
      `CHK(timer4_clock_input, i[0])
      `CHK({port_h_input_en, port_h_read}, {8'hff, port_h_pin_in})
      `CHK(pin_change_source, port_j_pin_in[6:0])
      `CHK({serial3_external_clock, serial3_receive_line}, {port_j_pin_in[2], port_j_pin_in[0]})
    end
    $display("test inputs done");
  endtask : t_inputs
  // -------------------------------------------------------
  // main sequence
  // -------------------------------------------------------
  initial begin
    {mclk, sys_rst, global_pullup_disable, bad_count, n_checks, cycles} = {2'h1, 1'b0, 96'h0};
    {port_g_direction, port_g_output, port_g_pin_in} = 18'h3ffff;
    {port_h_direction, port_h_output, port_h_pin_in, port_j_pin_in} = 32'h0;
    {timer0_compare_b_enable, timer2_async_clock_select, external_clock_input_select, timer2_compare_b_enable,
     timer4_compare_a_enable, timer4_compare_b_enable, timer4_compare_c_enable, ext_memory_interface_enable,
     serial2_sync_mode, serial2_transmitter_enable, serial2_receiver_enable} = 11'h0;
    repeat (2) tick();
    `CHK({port_g_dir, port_g_out, port_g_input_en}, 18'h0)
    sys_rst = 1'b0;
    t_extmem();
    t_osc();
    t_cmp();
    t_serial();
    t_inputs();
    conclude();
  end
endmodule : tb_top
